// >>> common/dual_timer_map.vh
// Register offsets, field positions, reset values and codes of the dual timer
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH
`define ADDR_COUNT_SOURCE 4'h0
`define ADDR_MODE_CONTROL 4'h1
`define ADDR_OUTPUT_CONTROL 4'h2
`define ADDR_LOW_COMPARE 4'h3
`define ADDR_HIGH_COMPARE 4'h4
`define ADDR_LOW_COUNTER 4'h5
`define ADDR_HIGH_COUNTER 4'h6
`define ADDR_WIDE_COUNTER 4'h7
`define ADDR_OSC_MODE 4'h8
`define ADDR_IRQ_STATUS 4'h9
`define MODE_RUN_BIT 0
`define MODE_CASCADE_BIT 2
`define OUT_TOGGLE_ONE 0
`define OUT_FLOP_ONE_RESET 2
`define OUT_FLOP_ONE_SET 3
`define OUT_TOGGLE_TWO 4
`define OUT_FLOP_TWO_RESET 6
`define OUT_FLOP_TWO_SET 7
`define OSC_DIVIDE_BIT 0
`define RESET_BYTE 8'h00
`define SRC_EVENT_FALL 4'h0
`define SRC_EVENT_RISE 4'h1
`define SRC_INT_FIRST 4'h6
`define SRC_INT_MAX 4'hE
`define SRC_INT_LONG 4'hF
`define PRESCALE_WIDTH 13
`endif

// >>> logic/edge_tick_select.v
// Count-source selector: event edge or prescaler tap for one channel
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_map.vh"
module edge_tick_select
(
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Selection
	input wire [3:0] select_i,
	input wire [`PRESCALE_WIDTH-1:0] prescale_i,
	input wire divide_by_one_i,
	// Event pin, already synchronised
	input wire event_i,
	// Count pulse
	output reg tick_o
);
	reg event_prev;
	reg [`PRESCALE_WIDTH-1:0] prescale_prev;
	reg [3:0] tap;
	reg tap_valid;
	wire [`PRESCALE_WIDTH-1:0] fall = prescale_prev & ~prescale_i;

	// Tap index k gives a period of 2^(k+1) system clocks; code 1111 skips one step
	always @*
	begin
		tap_valid = 1'b1;
		tap = 4'h0;
		if (select_i >= `SRC_INT_FIRST && select_i <= `SRC_INT_MAX)
			tap = select_i - `SRC_INT_FIRST;
		else if (select_i == `SRC_INT_LONG)
			tap = 4'hA;
		else
			tap_valid = 1'b0;
		if (!divide_by_one_i)
			tap = tap + 4'h1;
	end

	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			event_prev <= 1'b0;
			prescale_prev <= {`PRESCALE_WIDTH{1'b0}};
			tick_o <= 1'b0;
		end
		else
		begin
			event_prev <= event_i;
			prescale_prev <= prescale_i;
			if (select_i == `SRC_EVENT_FALL)
				tick_o <= event_prev & ~event_i;
			else if (select_i == `SRC_EVENT_RISE)
				tick_o <= ~event_prev & event_i;
			else
				tick_o <= tap_valid & fall[tap];
		end
	end
endmodule // edge_tick_select
`default_nettype wire

// >>> logic/dual_timer.v
// Dual 8-bit timer/event counter with cascade mode and Avalon-MM registers
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_map.vh"
module dual_timer
(
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Avalon-MM slave
	input wire [3:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [3:0] byteenable_i,
	input wire [31:0] writedata_i,
	output reg [31:0] readdata_o,
	output wire waitrequest_o,
	// Event pins
	input wire event_input_one_i,
	input wire event_input_two_i,
	// Toggle output pins
	output reg toggle_output_one_o,
	output reg toggle_output_two_o,
	// Match interrupt pulses
	output reg match_irq_one_o,
	output reg match_irq_two_o
);
	reg [7:0] count_source_select;
	reg [7:0] timer_mode_control;
	reg [7:0] output_control;
	reg [7:0] low_channel_compare;
	reg [7:0] high_channel_compare;
	reg [7:0] low_channel_counter;
	reg [7:0] high_channel_counter;
	reg [7:0] oscillation_mode_select;
	reg [1:0] irq_seen;
	reg [`PRESCALE_WIDTH-1:0] prescale;
	reg [1:0] ev_one_sync;
	reg [1:0] ev_two_sync;
	reg answered;
	reg [7:0] next_low;
	reg [7:0] next_high;
	reg low_match;
	reg high_match;
	reg low_wrap;
	reg high_inc;
	reg wide_match;
	wire low_tick;
	wire high_tick;
	wire cascade_mode_bit = timer_mode_control[`MODE_CASCADE_BIT];
	wire count_run_bit = timer_mode_control[`MODE_RUN_BIT];
	wire oscillator_divide_bit = oscillation_mode_select[`OSC_DIVIDE_BIT];
	wire low_clock_select_field_run = count_run_bit;
	wire toggle_enable_one = output_control[`OUT_TOGGLE_ONE];
	wire toggle_enable_two = output_control[`OUT_TOGGLE_TWO];
	wire access = (read_i | write_i) & ~answered;
	wire wr = write_i & access & byteenable_i[0];

	// Merge a byte lane into an 8-bit register
	function [7:0] lane0;
		input [7:0] old;
		input [31:0] data;
		input [3:0] be;
		begin
			lane0 = be[0] ? data[7:0] : old;
		end
	endfunction

	// One wait cycle per access, then the answer
	assign waitrequest_o = (read_i | write_i) & ~answered;

	// Pins from outside pass two flops first
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ev_one_sync <= 2'b00;
			ev_two_sync <= 2'b00;
		end
		else
		begin
			ev_one_sync <= {ev_one_sync[0], event_input_one_i};
			ev_two_sync <= {ev_two_sync[0], event_input_two_i};
		end
	end

	// Prescaler: free counter whose bit k falls every 2^(k+1) system clocks
	always @(posedge clk_i)
	begin
		if (reset_i)
			prescale <= {`PRESCALE_WIDTH{1'b0}};
		else
			prescale <= prescale + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
	end

	edge_tick_select low_select
	(
		.clk_i(clk_i),
		.reset_i(reset_i),
		.select_i(count_source_select[3:0]),
		.prescale_i(prescale),
		.divide_by_one_i(oscillator_divide_bit),
		.event_i(ev_one_sync[1]),
		.tick_o(low_tick)
	);

	edge_tick_select high_select
	(
		.clk_i(clk_i),
		.reset_i(reset_i),
		.select_i(count_source_select[7:4]),
		.prescale_i(prescale),
		.divide_by_one_i(oscillator_divide_bit),
		.event_i(ev_two_sync[1]),
		.tick_o(high_tick)
	);

	// Counting and match detection
	always @*
	begin
		next_low = low_channel_counter;
		next_high = high_channel_counter;
		low_match = 1'b0;
		high_match = 1'b0;
		low_wrap = 1'b0;
		high_inc = 1'b0;
		wide_match = 1'b0;
		if (low_clock_select_field_run && low_tick)
		begin
			low_match = (low_channel_counter == low_channel_compare);
			if (cascade_mode_bit)
			begin
				wide_match = low_match && (high_channel_counter == high_channel_compare);
				if (wide_match)
				begin
					next_low = 8'h00;
					next_high = 8'h00;
				end
				else
				begin
					// Low-only match raises irq one but keeps counting, so the wide period is H*256 plus N plus one
					next_low = low_channel_counter + 8'h01;
					low_wrap = (low_channel_counter == 8'hFF);
					high_inc = low_wrap;
					next_high = high_inc ? high_channel_counter + 8'h01 : high_channel_counter;
				end
			end
			else
				next_low = low_match ? 8'h00 : low_channel_counter + 8'h01;
		end
		// Independent high channel runs under the same run bit
		if (!cascade_mode_bit && count_run_bit && high_tick)
		begin
			high_match = (high_channel_counter == high_channel_compare);
			next_high = high_match ? 8'h00 : high_channel_counter + 8'h01;
		end
	end

	// Counters, outputs and registers
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			count_source_select <= `RESET_BYTE;
			timer_mode_control <= `RESET_BYTE;
			output_control <= `RESET_BYTE;
			low_channel_compare <= `RESET_BYTE;
			high_channel_compare <= `RESET_BYTE;
			oscillation_mode_select <= `RESET_BYTE;
			low_channel_counter <= `RESET_BYTE;
			high_channel_counter <= `RESET_BYTE;
			toggle_output_one_o <= 1'b0;
			toggle_output_two_o <= 1'b0;
			match_irq_one_o <= 1'b0;
			match_irq_two_o <= 1'b0;
			irq_seen <= 2'b00;
			answered <= 1'b0;
			readdata_o <= 32'h00000000;
		end
		else
		begin
			answered <= access;
			low_channel_counter <= next_low;
			high_channel_counter <= next_high;
			match_irq_one_o <= low_match;
			match_irq_two_o <= cascade_mode_bit ? wide_match : high_match;
			if (toggle_enable_one && low_match)
				toggle_output_one_o <= ~toggle_output_one_o;
			if (toggle_enable_two && (cascade_mode_bit ? wide_match : high_match))
				toggle_output_two_o <= ~toggle_output_two_o;
			// Sticky seen flags: set wins over a clear in the same cycle
			irq_seen <= irq_seen;
			if (wr && address_i == `ADDR_IRQ_STATUS)
				irq_seen <= irq_seen & ~writedata_i[1:0];
			if (low_match)
				irq_seen[0] <= 1'b1;
			if (cascade_mode_bit ? wide_match : high_match)
				irq_seen[1] <= 1'b1;
			if (wr)
			begin
				case (address_i)
					`ADDR_COUNT_SOURCE: count_source_select <= writedata_i[7:0];
					`ADDR_MODE_CONTROL: timer_mode_control <= writedata_i[7:0];
					`ADDR_OUTPUT_CONTROL:
					begin
						// Preset bits act once and read back as zero
						output_control <= writedata_i[7:0] & 8'h33;
						if (writedata_i[`OUT_FLOP_ONE_SET])
							toggle_output_one_o <= 1'b1;
						else if (writedata_i[`OUT_FLOP_ONE_RESET])
							toggle_output_one_o <= 1'b0;
						if (writedata_i[`OUT_FLOP_TWO_SET])
							toggle_output_two_o <= 1'b1;
						else if (writedata_i[`OUT_FLOP_TWO_RESET])
							toggle_output_two_o <= 1'b0;
					end
					`ADDR_LOW_COMPARE: low_channel_compare <= writedata_i[7:0];
					`ADDR_HIGH_COMPARE: high_channel_compare <= writedata_i[7:0];
					`ADDR_WIDE_COUNTER:
					begin
						low_channel_compare <= lane0(low_channel_compare, writedata_i, byteenable_i);
						if (byteenable_i[1])
							high_channel_compare <= writedata_i[15:8];
					end
					`ADDR_OSC_MODE: oscillation_mode_select <= writedata_i[7:0];
					default: readdata_o <= readdata_o;
				endcase
			end
			if (read_i && access)
			begin
				case (address_i)
					`ADDR_COUNT_SOURCE: readdata_o <= {24'h000000, count_source_select};
					`ADDR_MODE_CONTROL: readdata_o <= {24'h000000, timer_mode_control};
					`ADDR_OUTPUT_CONTROL: readdata_o <= {24'h000000, output_control};
					`ADDR_LOW_COMPARE: readdata_o <= {24'h000000, low_channel_compare};
					`ADDR_HIGH_COMPARE: readdata_o <= {24'h000000, high_channel_compare};
					`ADDR_LOW_COUNTER: readdata_o <= {24'h000000, low_channel_counter};
					`ADDR_HIGH_COUNTER: readdata_o <= {24'h000000, high_channel_counter};
					`ADDR_WIDE_COUNTER:
						readdata_o <= {16'h0000, high_channel_counter, low_channel_counter};
					`ADDR_OSC_MODE: readdata_o <= {24'h000000, oscillation_mode_select};
					`ADDR_IRQ_STATUS: readdata_o <= {28'h0000000, toggle_output_two_o,
						toggle_output_one_o, irq_seen};
					default: readdata_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // dual_timer
`default_nettype wire

// >>> tb/dual_timer_properties.sv
// Port properties of the dual timer
`timescale 1ns/10ps
`default_nettype none
module dual_timer_properties
(
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Bus
	input wire [3:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] readdata_o,
	input wire waitrequest_o,
	// Pins
	input wire toggle_output_one_o,
	input wire toggle_output_two_o,
	input wire match_irq_one_o,
	input wire match_irq_two_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	sequence s_req;
		(read_i || write_i) && !$past(read_i || write_i);
	endsequence
	sequence s_ans;
		waitrequest_o ##1 !waitrequest_o;
	endsequence
	a_one_wait: assert property (s_req |-> s_ans)
		else $error("bad wait");
	a_unmapped_zero: assert property (read_i && !waitrequest_o && address_i > 4'h9
		|-> readdata_o == 32'h0) else $error("unmapped data");
	a_data_cause: assert property ($changed(readdata_o) |-> $past(read_i))
		else $error("data moved");
	a_reset_quiet: assert property (disable iff (1'b0) $past(reset_i) |->
		!match_irq_one_o && !match_irq_two_o && !toggle_output_one_o && !toggle_output_two_o)
		else $error("reset outputs");
	a_irq_one_pulse: assert property (match_irq_one_o |=> !match_irq_one_o)
		else $error("irq one long");
	a_irq_two_pulse: assert property (match_irq_two_o |=> !match_irq_two_o)
		else $error("irq two long");
	a_flop_one_cause: assert property ($changed(toggle_output_one_o) |->
		match_irq_one_o || $past(match_irq_one_o) || $past(write_i)) else $error("flop one");
	a_flop_two_cause: assert property ($changed(toggle_output_two_o) |->
		match_irq_two_o || $past(match_irq_two_o) || $past(write_i)) else $error("flop two");
endmodule // dual_timer_properties
bind dual_timer dual_timer_properties dual_timer_properties_i (.clk_i(clk_i),
	.reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
	.readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
	.toggle_output_one_o(toggle_output_one_o), .toggle_output_two_o(toggle_output_two_o),
	.match_irq_one_o(match_irq_one_o), .match_irq_two_o(match_irq_two_o));
`default_nettype wire

// >>> tb/event_source.sv
// External event pin source
`timescale 1ns/10ps
`default_nettype none
module event_source
(
	// Clock
	input wire clk_i,
	// Event pins
	output var logic event_one_o,
	output var logic event_two_o
);
	initial
	begin
		event_one_o = 1'b0;
		event_two_o = 1'b0;
	end
	// Levels held four clocks, above the two-clock minimum width
	task automatic level(input int ch, input logic v);
		@(posedge clk_i);
		if (ch == 1)
			event_one_o <= v;
		else
			event_two_o <= v;
		repeat (3) @(posedge clk_i);
	endtask
endmodule // event_source
`default_nettype wire

// >>> tb/tb_dual_timer.sv
// Self-checking bench of the dual timer
`timescale 1ns/10ps
`default_nettype none
module tb_dual_timer;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] address_i = 4'h0;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [3:0] byteenable_i = 4'h0;
	logic [31:0] writedata_i = 32'h0;
	logic [31:0] rd;
	logic [31:0] lo;
	wire [31:0] readdata_o;
	wire waitrequest_o, ev1, ev2, tog1, tog2, irq1, irq2;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	int ones = 0;
	int t0, t1, o0, n, h, c, d;
	dual_timer dual_timer_i (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
		.writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.event_input_one_i(ev1), .event_input_two_i(ev2), .toggle_output_one_o(tog1),
		.toggle_output_two_o(tog2), .match_irq_one_o(irq1), .match_irq_two_o(irq2));
	event_source event_source_i (.clk_i(clk_i), .event_one_o(ev1), .event_two_o(ev2));
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (irq1 === 1'b1)
			ones <= ones + 1;
	end
	task automatic give_verdict();
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is sampled low at a rising edge, released at that edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] v,
		input logic [3:0] be);
		@(posedge clk_i);
		address_i <= a;
		writedata_i <= v;
		byteenable_i <= be;
		read_i <= !wr;
		write_i <= wr;
		do
			@(posedge clk_i);
		while (waitrequest_o !== 1'b0);
		rd = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask
	// Two-edge reset clears counters left over from the last scenario
	task automatic restart();
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
	endtask
	task automatic wait_irq(input int ch, output int t);
		int k;
		k = 0;
		do
		begin
			@(negedge clk_i);
			k++;
		end
		while ((ch == 1 ? irq1 : irq2) !== 1'b1 && k < 20000);
		t = cyc;
		if (k >= 20000)
			errors++;
	endtask
	task automatic pulse(input int ch);
		event_source_i.level(ch, 1'b1);
		event_source_i.level(ch, 1'b0);
	endtask
	function automatic int tick_len(input int code, input int div);
		tick_len = ((code == 15) ? 2048 : (1 << (code - 5))) * (div ? 1 : 2);
	endfunction
	initial
	begin
		#6000000;
		errors++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(97752));
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		bus(0, 4'h5, 0, 4'hF);
		check(rd, 32'h0);
		bus(0, 4'hC, 0, 4'hF);
		check(rd, 32'h0);
		bus(1, 4'h0, 32'h11, 4'h1);
		bus(1, 4'h3, 32'hFF, 4'h1);
		bus(1, 4'h4, 32'hFF, 4'h1);
		bus(1, 4'h1, 32'h1, 4'h1);
		n = $urandom_range(6, 1);
		repeat (n) pulse(1);
		repeat (n + 1) pulse(2);
		bus(0, 4'h5, 0, 4'hF);
		check(rd, n);
		bus(0, 4'h6, 0, 4'hF);
		check(rd, n + 1);
		bus(1, 4'h1, 32'h0, 4'h1);
		bus(1, 4'h0, 32'h0, 4'h1);
		bus(1, 4'h1, 32'h1, 4'h1);
		event_source_i.level(1, 1'b1);
		bus(0, 4'h5, 0, 4'hF);
		check(rd, n);
		event_source_i.level(1, 1'b0);
		bus(0, 4'h5, 0, 4'hF);
		check(rd, n + 1);
		for (c = 6; c < 16; c++)
		begin
			d = (c > 11) ? 1 : $urandom_range(1, 0);
			n = (c > 11) ? 0 : $urandom_range(7, 0);
			restart();
			bus(1, 4'h8, d, 4'h1);
			bus(1, 4'h0, {c[3:0], c[3:0]}, 4'h1);
			bus(1, 4'h3, n, 4'h1);
			bus(1, 4'h4, n ^ 1, 4'h1);
			bus(1, 4'h2, 32'h99, 4'h1);
			@(negedge clk_i);
			check({tog2, tog1}, 2'b11);
			bus(1, 4'h1, 32'h1, 4'h1);
			wait_irq(1, t0);
			@(negedge clk_i);
			check(tog1, 1'b0);
			wait_irq(1, t1);
			check(t1 - t0, (n + 1) * tick_len(c, d));
			wait_irq(2, t0);
			wait_irq(2, t1);
			check(t1 - t0, ((n ^ 1) + 1) * tick_len(c, d));
		end
		restart();
		bus(1, 4'h8, 32'h1, 4'h1);
		bus(1, 4'h0, 32'h6, 4'h1);
		h = $urandom_range(3, 0);
		n = $urandom_range(255, 0);
		bus(1, 4'h7, {h[7:0], n[7:0]}, 4'h3);
		bus(1, 4'h2, 32'h88, 4'h1);
		bus(1, 4'h2, 32'h44, 4'h1);
		@(negedge clk_i);
		check({tog2, tog1}, 2'b00);
		bus(1, 4'h1, 32'h5, 4'h1);
		wait_irq(2, t0);
		o0 = ones;
		wait_irq(2, t1);
		check(t1 - t0, (h * 256 + n + 1) * tick_len(6, 1));
		check(ones - o0, h + 1);
		bus(1, 4'h1, 32'h4, 4'h1);
		bus(0, 4'h7, 0, 4'hF);
		lo = rd;
		bus(0, 4'h5, 0, 4'hF);
		check(rd, {24'h0, lo[7:0]});
		bus(0, 4'h6, 0, 4'hF);
		check(rd, {24'h0, lo[15:8]});
		bus(0, 4'h9, 0, 4'hF);
		check(rd[1:0], 2'b11);
		bus(1, 4'h9, 32'h3, 4'h1);
		bus(0, 4'h9, 0, 4'hF);
		check(rd[1:0], 2'b00);
		give_verdict();
	end
endmodule // tb_dual_timer
`default_nettype wire
